// ---- pkg/tap_regs.svh ----
// Constants for the test access port and its tester end.
// Assumes inclusion by bare name from package and design files.
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH

`define TAP_IR_W 3
`define TAP_IR_EXTEST 3'h0
`define TAP_IR_IDCODE 3'h1
`define TAP_IR_SAMPLE 3'h4
`define TAP_IR_HIGHZ 3'h5
`define TAP_IR_BYPASS 3'h7
`define TAP_IR_CAPTURE 3'h1
`define TAP_ID_W 32
`define TAP_ID_VALUE 32'h0a5a_5a5b
`define TAP_BSR_LEN 8
`define TAP_RESET_EDGES 5
`define TST_HALF_CYC 4
`define TST_PRE_IR 6'h03
`define TST_PRE_IR_LEN 6'h04
`define TST_PRE_DR 6'h01
`define TST_PRE_DR_LEN 6'h03
`define TST_PRE_RST 6'h1f
`define TST_PRE_RST_LEN 6'h06
`define TST_POST 6'h01
`define TST_POST_LEN 6'h02

`endif

// ---- pkg/tap_pkg.sv ----
// Types shared by the test access port and its tester end.
// Assumes tap_regs.svh on the include path.
`include "tap_regs.svh"

package tap_pkg;
	typedef enum logic [3:0] {
		TLR = 4'h0,
		RTI = 4'h1,
		SEL_DR = 4'h2,
		CAP_DR = 4'h3,
		SH_DR = 4'h4,
		EX1_DR = 4'h5,
		PAU_DR = 4'h6,
		EX2_DR = 4'h7,
		UPD_DR = 4'h8,
		SEL_IR = 4'h9,
		CAP_IR = 4'ha,
		SH_IR = 4'hb,
		EX1_IR = 4'hc,
		PAU_IR = 4'hd,
		EX2_IR = 4'he,
		UPD_IR = 4'hf
	} tap_state_t;

	typedef enum logic [1:0] {
		T_IDLE = 2'h0,
		T_PRE = 2'h1,
		T_SHIFT = 2'h2,
		T_POST = 2'h3
	} tst_state_t;

	typedef enum logic [1:0] {
		CMD_IR = 2'h0,
		CMD_DR = 2'h1,
		CMD_RESET = 2'h2
	} tst_cmd_t;
endpackage : tap_pkg

// ---- pkg/tap_if.sv ----
// Pin-level link between the test access port and the tester.
// Assumes both ends connect through their modports; pull-ups are resolved here.
`timescale 1ns/10ps
`default_nettype none

interface tap_if;
	logic tck;
	logic tms_o;
	logic tms_oe;
	logic tdi_o;
	logic tdi_oe;
	logic trst_o;
	logic trst_oe;
	logic tdo_o;
	logic tdo_oe;
	logic tms;
	logic tdi;
	logic trst_b;
	logic tdo;

	// Undriven inputs read high through the pad pull-ups
	assign tms = tms_oe ? tms_o : 1'b1;
	assign tdi = tdi_oe ? tdi_o : 1'b1;
	assign trst_b = trst_oe ? trst_o : 1'b1;
	assign tdo = tdo_oe ? tdo_o : 1'b1;

	modport dev (input tck, input tms, input tdi, input trst_b, output tdo_o, output tdo_oe);
	modport tst (output tck, output tms_o, output tms_oe, output tdi_o, output tdi_oe,
		output trst_o, output trst_oe, input tdo);
endinterface : tap_if

`default_nettype wire

// ---- rtl/tap_device.sv ----
// Test access port of the processor: controller, instruction and data registers.
// Assumes the pins arrive through tap_if; clk_i is the bus clock for debug mode.
// Behaviour
// [RL1] Strap high: JTAG pins; low: debug port
// [RL2] TDI enters selected register on rising TCK
// [RL3] TDI pulled up, idle reads one
// [RL4] TDO changes on falling TCK edge
// [RL5] TDO undriven when not shifting out
// [RL6] Test reset forces reset state, IDCODE
// [RL7] Reset state leaves system pins untouched
// [RL8] Tester releases reset with TMS high
// [RL9] Test reset pin pulled up
// [RL10] Next state from TMS at rising TCK
// [RL11] Five TMS-high edges reach reset state
// [RL12] Instruction shift register three bits, no parity
// [RL13] Update-IR falling edge loads hold register
// [RL14] Tester presents bits before sampling edge
// [RL15] Instruction register shifts LSB out first
// [RL16] Debug clock at most half bus clock
// [RL17] Encodings 000,001,100,101; IDCODE default
// [RL18] Capture-DR loads identity, LSB one
// [RL19] HIGHZ selects bypass, floats pins
// [RL20] TDO driven only in Shift-IR, Shift-DR
`timescale 1ns/10ps
`default_nettype none
`include "tap_regs.svh"

module tap_device
	import tap_pkg::*;
#(
	parameter int BSR_LEN = `TAP_BSR_LEN,
	parameter logic [`TAP_ID_W-1:0] ID_VALUE = `TAP_ID_VALUE // Arbitrary value, LSB one
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	tap_if.dev pins,
	input wire logic test_port_select_strap_i,
	input wire logic [BSR_LEN-1:0] sys_pins_i,
	output logic [BSR_LEN-1:0] bsr_update_o,
	output logic extest_active_o,
	output logic pins_highz_o,
	input wire logic debug_serial_out_i,
	input wire logic debug_serial_out_oe_i,
	output logic debug_serial_in_o,
	output logic debug_serial_clock_o,
	output logic hardware_breakpoint_request_o
);
	typedef struct packed {
		tap_state_t st;
		logic [`TAP_IR_W-1:0] ir_sr;
		logic [`TAP_ID_W-1:0] id_sr;
		logic byp;
		logic [BSR_LEN-1:0] bsr_sr;
		logic [BSR_LEN-1:0] smp1;
		logic [BSR_LEN-1:0] smp2;
	} rise_t;

	typedef struct packed {
		logic [`TAP_IR_W-1:0] ir_hold;
		logic tdo;
		logic tdo_en;
		logic [BSR_LEN-1:0] bsr_upd;
	} fall_t;

	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
	} dbg_t;

	rise_t r_ff;
	rise_t nxt_r;
	fall_t f_ff;
	fall_t nxt_f;
	dbg_t d_ff;
	dbg_t nxt_d;
	logic tap_rst_b;
	logic sel_bsr;
	logic sel_id;

	// Debug mode keeps the whole test logic in reset
	assign tap_rst_b = pins.trst_b & test_port_select_strap_i; // [RL1] [RL6] [RL9]

	assign sel_bsr = (f_ff.ir_hold == `TAP_IR_EXTEST) || (f_ff.ir_hold == `TAP_IR_SAMPLE);
	assign sel_id = (f_ff.ir_hold == `TAP_IR_IDCODE);

	function automatic tap_state_t next_state(input tap_state_t s, input logic tms);
		case (s)
			TLR: next_state = tms ? TLR : RTI;
			RTI: next_state = tms ? SEL_DR : RTI;
			SEL_DR: next_state = tms ? SEL_IR : CAP_DR;
			CAP_DR: next_state = tms ? EX1_DR : SH_DR;
			SH_DR: next_state = tms ? EX1_DR : SH_DR;
			EX1_DR: next_state = tms ? UPD_DR : PAU_DR;
			PAU_DR: next_state = tms ? EX2_DR : PAU_DR;
			EX2_DR: next_state = tms ? UPD_DR : SH_DR;
			UPD_DR: next_state = tms ? SEL_DR : RTI;
			SEL_IR: next_state = tms ? TLR : CAP_IR;
			CAP_IR: next_state = tms ? EX1_IR : SH_IR;
			SH_IR: next_state = tms ? EX1_IR : SH_IR;
			EX1_IR: next_state = tms ? UPD_IR : PAU_IR;
			PAU_IR: next_state = tms ? EX2_IR : PAU_IR;
			EX2_IR: next_state = tms ? UPD_IR : SH_IR;
			UPD_IR: next_state = tms ? SEL_DR : RTI;
			default: next_state = TLR;
		endcase
	endfunction : next_state

	// Rising TCK: controller, capture and shift
	always_comb begin
		nxt_r = r_ff;
		nxt_r.st = next_state(r_ff.st, pins.tms); // [RL10] [RL11]
		// System pins are asynchronous to TCK, so samples pass two stages
		nxt_r.smp1 = sys_pins_i;
		nxt_r.smp2 = r_ff.smp1;
		case (r_ff.st)
			CAP_IR: begin
				nxt_r.ir_sr = `TAP_IR_CAPTURE;
			end
			SH_IR: begin
				nxt_r.ir_sr = {pins.tdi, r_ff.ir_sr[`TAP_IR_W-1:1]}; // [RL2] [RL3] [RL12] [RL15]
			end
			CAP_DR: begin
				nxt_r.byp = 1'b0;
				if (sel_id) begin
					nxt_r.id_sr = ID_VALUE; // [RL18]
				end
				if (sel_bsr) begin
					nxt_r.bsr_sr = r_ff.smp2;
				end
			end
			SH_DR: begin
				nxt_r.byp = pins.tdi; // [RL2]
				if (sel_id) begin
					nxt_r.id_sr = {pins.tdi, r_ff.id_sr[`TAP_ID_W-1:1]};
				end
				if (sel_bsr) begin
					nxt_r.bsr_sr = {pins.tdi, r_ff.bsr_sr[BSR_LEN-1:1]};
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge pins.tck or negedge tap_rst_b) begin
		if (!tap_rst_b) begin
			r_ff <= '0; // [RL6]
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Falling TCK: output data, instruction and boundary update
	always_comb begin
		nxt_f = f_ff;
		nxt_f.tdo_en = (r_ff.st == SH_IR) || (r_ff.st == SH_DR); // [RL5] [RL20]
		if (r_ff.st == SH_IR) begin
			nxt_f.tdo = r_ff.ir_sr[0]; // [RL4] [RL15]
		end else if (sel_id) begin
			nxt_f.tdo = r_ff.id_sr[0]; // [RL4]
		end else if (sel_bsr) begin
			nxt_f.tdo = r_ff.bsr_sr[0];
		end else begin
			nxt_f.tdo = r_ff.byp; // [RL19]
		end
		case (r_ff.st)
			TLR: begin
				nxt_f.ir_hold = `TAP_IR_IDCODE; // [RL17]
			end
			UPD_IR: begin
				nxt_f.ir_hold = r_ff.ir_sr; // [RL13] [RL19]
			end
			UPD_DR: begin
				if (sel_bsr) begin
					nxt_f.bsr_upd = r_ff.bsr_sr;
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(negedge pins.tck or negedge tap_rst_b) begin
		if (!tap_rst_b) begin
			f_ff <= '{ir_hold: `TAP_IR_IDCODE, tdo: 1'b0, tdo_en: 1'b0, bsr_upd: '0}; // [RL6] [RL17]
		end else begin
			f_ff <= nxt_f;
		end
	end

	// Reset holds IDCODE, so neither pin override is active then
	assign extest_active_o = (f_ff.ir_hold == `TAP_IR_EXTEST); // [RL7] [RL17]
	assign pins_highz_o = (f_ff.ir_hold == `TAP_IR_HIGHZ); // [RL7] [RL19]
	assign bsr_update_o = f_ff.bsr_upd;

	// Debug port: TDO carries the serial output when the strap is low
	assign pins.tdo_o = test_port_select_strap_i ? f_ff.tdo : debug_serial_out_i; // [RL1]
	assign pins.tdo_oe = test_port_select_strap_i ? f_ff.tdo_en : debug_serial_out_oe_i; // [RL1]

	// Debug pins synchronised to the bus clock; relies on a slow enough serial clock
	always_comb begin
		nxt_d.s1 = {pins.tms, pins.trst_b, pins.tdi}; // [RL16]
		nxt_d.s2 = d_ff.s1;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			d_ff <= '{s1: 3'h6, s2: 3'h6};
		end else begin
			d_ff <= nxt_d;
		end
	end

	// Quiet while JTAG owns the pins
	assign debug_serial_in_o = !test_port_select_strap_i & d_ff.s2[0]; // [RL1]
	assign debug_serial_clock_o = !test_port_select_strap_i & d_ff.s2[1]; // [RL1]
	assign hardware_breakpoint_request_o = !test_port_select_strap_i & !d_ff.s2[2]; // [RL1]
endmodule : tap_device

`default_nettype wire

// ---- rtl/tap_tester.sv ----
// Board tester end: makes TCK from clk_i and runs IR, DR and reset scans.
// Assumes the device end sits on the other side of tap_if.
`timescale 1ns/10ps
`default_nettype none
`include "tap_regs.svh"

module tap_tester
	import tap_pkg::*;
#(
	parameter int HALF_CYC = `TST_HALF_CYC
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	tap_if.tst pins,
	input wire logic trst_req_i,
	input wire logic debug_mode_i,
	input wire logic dbg_si_i,
	input wire logic dbg_hardware_breakpoint_request_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire tst_cmd_t cmd_kind_i,
	input wire logic [5:0] cmd_len_i,
	input wire logic [31:0] cmd_data_i,
	output logic rsp_valid_o,
	output logic [31:0] rsp_data_o,
	output logic dbg_so_o
);
	typedef struct packed {
		tst_state_t st;
		logic [7:0] div;
		logic tck;
		logic tms;
		logic tdi;
		logic trst_n;
		logic [5:0] pat;
		logic [5:0] cnt;
		logic [5:0] len;
		logic [31:0] sr;
		logic [31:0] rx;
		logic rsp_v;
		logic [31:0] rsp;
		logic tdo1;
		logic tdo2;
	} tst_t;

	tst_t s_ff;
	tst_t nxt;
	logic tick;
	logic fall;
	logic rise;

	assign tick = (s_ff.div == 8'(HALF_CYC - 1));
	assign fall = tick & s_ff.tck;
	assign rise = tick & !s_ff.tck;
	assign cmd_ready_o = (s_ff.st == T_IDLE) & fall & s_ff.trst_n & !debug_mode_i;

	always_comb begin
		nxt = s_ff;
		nxt.rsp_v = 1'b0;
		nxt.tdo1 = pins.tdo;
		nxt.tdo2 = s_ff.tdo1;
		nxt.trst_n = !trst_req_i;
		nxt.div = tick ? 8'h00 : s_ff.div + 8'h01;
		// Divided clock doubles as the debug serial clock, never above half clk_i
		if (tick) begin
			nxt.tck = !s_ff.tck; // [RL16]
		end
		if (!s_ff.trst_n || trst_req_i) begin
			nxt.tms = 1'b1; // [RL8]
			nxt.st = T_IDLE;
		end else if (fall) begin
			// Data set up half a period ahead of the sampling edge
			case (s_ff.st)
				T_IDLE: begin
					nxt.tms = 1'b0;
					nxt.tdi = 1'b1;
					if (cmd_ready_o && cmd_valid_i) begin
						nxt.st = T_PRE;
						nxt.sr = cmd_data_i;
						nxt.len = (cmd_kind_i == CMD_RESET) ? 6'h00 : cmd_len_i;
						case (cmd_kind_i)
							CMD_IR: begin
								nxt.pat = `TST_PRE_IR;
								nxt.cnt = `TST_PRE_IR_LEN;
							end
							CMD_DR: begin
								nxt.pat = `TST_PRE_DR;
								nxt.cnt = `TST_PRE_DR_LEN;
							end
							default: begin
								nxt.pat = `TST_PRE_RST;
								nxt.cnt = `TST_PRE_RST_LEN;
							end
						endcase
						nxt.tms = nxt.pat[0];
					end
				end
				T_PRE, T_POST: begin
					nxt.tms = s_ff.pat[0];
				end
				T_SHIFT: begin
					nxt.tms = (s_ff.cnt == 6'h01);
					nxt.tdi = s_ff.sr[0]; // [RL14]
				end
				default: begin
					nxt.st = T_IDLE;
				end
			endcase
		end else if (rise) begin
			case (s_ff.st)
				T_PRE, T_POST: begin
					nxt.pat = {1'b0, s_ff.pat[5:1]};
					nxt.cnt = s_ff.cnt - 6'h01;
					if (s_ff.cnt == 6'h01) begin
						if (s_ff.st == T_PRE && s_ff.len != 6'h00) begin
							nxt.st = T_SHIFT;
							nxt.cnt = s_ff.len;
							nxt.rx = '0;
						end else begin
							nxt.st = T_IDLE;
							nxt.rsp_v = 1'b1;
							nxt.rsp = s_ff.rx >> (6'd32 - s_ff.len);
						end
					end
				end
				T_SHIFT: begin
					nxt.sr = {1'b0, s_ff.sr[31:1]};
					nxt.rx = {s_ff.tdo2, s_ff.rx[31:1]};
					nxt.cnt = s_ff.cnt - 6'h01;
					if (s_ff.cnt == 6'h01) begin
						nxt.st = T_POST;
						nxt.pat = `TST_POST;
						nxt.cnt = `TST_POST_LEN;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_ff <= '{st: T_IDLE, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0, tdo1: 1'b1, tdo2: 1'b1,
				default: '0};
		end else begin
			s_ff <= nxt;
		end
	end

	// Debug mode reuses the pins: TMS breakpoint, reset pin serial clock, TDI serial in
	assign pins.tck = debug_mode_i ? 1'b0 : s_ff.tck;
	assign pins.tms_o = debug_mode_i ? !dbg_hardware_breakpoint_request_i : s_ff.tms;
	assign pins.tms_oe = 1'b1;
	assign pins.tdi_o = debug_mode_i ? dbg_si_i : s_ff.tdi;
	// Held through the post walk: the last bit must not race the rising TCK
	assign pins.tdi_oe = debug_mode_i | (s_ff.st == T_SHIFT) | (s_ff.st == T_POST); // [RL14]
	assign pins.trst_o = debug_mode_i ? s_ff.tck : 1'b0;
	assign pins.trst_oe = debug_mode_i | !s_ff.trst_n;
	assign rsp_valid_o = s_ff.rsp_v;
	assign rsp_data_o = s_ff.rsp;
	assign dbg_so_o = s_ff.tdo2;
endmodule : tap_tester

`default_nettype wire

// ---- tb/tap_checks_props.sv ----
// Pin-level checks on the test port link, with a small reference controller.
// Assumes tester and device meet on one tap_if; tck comes from the tester.
`timescale 1ns/10ps
`default_nettype none
`include "tap_regs.svh"

module tap_checks
	import tap_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic test_port_select_strap_i,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_b,
	input wire logic tdo_o,
	input wire logic tdo_oe
);
	typedef struct packed {
		tap_state_t st;
		logic [2:0] sh;
		logic [2:0] hold;
		logic [2:0] cnt;
	} mdl_t;
	mdl_t m_ff;
	mdl_t nxt_m;
	wire logic tap_on = trst_b & test_port_select_strap_i;

	function automatic tap_state_t nx(input tap_state_t s, input logic m);
		case (s)
			TLR: nx = m ? TLR : RTI;
			RTI: nx = m ? SEL_DR : RTI;
			SEL_DR: nx = m ? SEL_IR : CAP_DR;
			CAP_DR: nx = m ? EX1_DR : SH_DR;
			SH_DR: nx = m ? EX1_DR : SH_DR;
			EX1_DR: nx = m ? UPD_DR : PAU_DR;
			PAU_DR: nx = m ? EX2_DR : PAU_DR;
			EX2_DR: nx = m ? UPD_DR : SH_DR;
			UPD_DR: nx = m ? SEL_DR : RTI;
			SEL_IR: nx = m ? TLR : CAP_IR;
			CAP_IR: nx = m ? EX1_IR : SH_IR;
			SH_IR: nx = m ? EX1_IR : SH_IR;
			EX1_IR: nx = m ? UPD_IR : PAU_IR;
			PAU_IR: nx = m ? EX2_IR : PAU_IR;
			EX2_IR: nx = m ? UPD_IR : SH_IR;
			default: nx = m ? SEL_DR : RTI;
		endcase
	endfunction : nx

	// Hold copied one rising edge late; only read later, so no loss
	always_comb begin
		nxt_m = m_ff;
		nxt_m.st = nx(m_ff.st, tms);
		nxt_m.cnt = tms ? (m_ff.cnt == 3'h7 ? 3'h7 : m_ff.cnt + 3'h1) : 3'h0;
		if (m_ff.st == CAP_IR) nxt_m.sh = `TAP_IR_CAPTURE;
		if (m_ff.st == SH_IR) nxt_m.sh = {tdi, m_ff.sh[2:1]};
		if (m_ff.st == UPD_IR) nxt_m.hold = m_ff.sh;
		if (m_ff.st == TLR) nxt_m.hold = `TAP_IR_IDCODE;
	end

	always_ff @(posedge tck or negedge tap_on) begin
		if (!tap_on) m_ff <= {TLR, 3'h1, `TAP_IR_IDCODE, 3'h0};
		else m_ff <= nxt_m;
	end

	oe_shift_a: assert property (@(posedge tck) disable iff (!tap_on)
		tdo_oe == (m_ff.st inside {SH_IR, SH_DR})) else $error("tdo enable wrong");
	five_tms_a: assert property (@(posedge tck) disable iff (!tap_on)
		m_ff.cnt >= 3'h5 |-> !tdo_oe) else $error("no reset after five");
	ir_capture_a: assert property (@(posedge tck) disable iff (!tap_on)
		m_ff.st == SH_IR && $past(m_ff.st) == CAP_IR |-> tdo_o) else $error("ir capture");
	ir_shift_a: assert property (@(posedge tck) disable iff (!tap_on)
		m_ff.st == SH_IR && $past(m_ff.st) == SH_IR && $past(m_ff.st, 2) == SH_IR
		&& $past(m_ff.st, 3) == SH_IR |-> tdo_o == $past(tdi, 3)) else $error("ir path");
	id_first_a: assert property (@(posedge tck) disable iff (!tap_on)
		m_ff.st == SH_DR && $past(m_ff.st) == CAP_DR && m_ff.hold == `TAP_IR_IDCODE
		|-> tdo_o) else $error("id lsb");
	bypass_first_a: assert property (@(posedge tck) disable iff (!tap_on)
		m_ff.st == SH_DR && $past(m_ff.st) == CAP_DR && !(m_ff.hold inside
		{`TAP_IR_EXTEST, `TAP_IR_IDCODE, `TAP_IR_SAMPLE}) |-> !tdo_o) else $error("bypass");
	trst_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!trst_b && test_port_select_strap_i |-> !tdo_oe) else $error("tdo on in reset");
	tdo_fall_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		test_port_select_strap_i && tdo_oe && $changed(tdo_o) |-> $fell(tck))
		else $error("tdo off edge");

	cover property (@(posedge tck) m_ff.cnt == 3'h5);
	cover property (@(posedge tck) m_ff.st == SH_DR && m_ff.hold == `TAP_IR_HIGHZ);
	cover property (@(posedge tck) m_ff.st == UPD_IR && m_ff.sh == `TAP_IR_EXTEST);
endmodule : tap_checks
`default_nettype wire

// ---- tb/jtag_tap_controller_ir_bench.sv ----
// Bench: tester end drives the device end over tap_if, random scans.
// Assumes default parameters of both ends; tck is made by the tester.
`timescale 1ns/10ps
`default_nettype none
`include "tap_regs.svh"

module jtag_tap_controller_ir_bench
	import tap_pkg::*;
;
	logic clk_i, rst_b_i, strap, so_i, so_oe, trq, dmode, si, hardware_breakpoint_request, cv, cr, rv;
	logic debug_serial_out, din, bk, ea, hz, dclk, tv;
	logic [7:0] sp, bsr;
	logic [5:0] cl;
	logic [31:0] cd, rd;
	logic [2:0] cur;
	logic [2:0] codes [6] = '{`TAP_IR_EXTEST, `TAP_IR_SAMPLE, `TAP_IR_HIGHZ,
		`TAP_IR_BYPASS, 3'h2, `TAP_IR_IDCODE};
	tst_cmd_t ck;
	int err_count, cmp_count, seed;

	tap_if pins();
	tap_device i_tap_device(.clk_i, .rst_b_i, .pins(pins), .test_port_select_strap_i(strap),
		.sys_pins_i(sp), .bsr_update_o(bsr), .extest_active_o(ea), .pins_highz_o(hz),
		.debug_serial_out_i(so_i), .debug_serial_out_oe_i(so_oe), .debug_serial_in_o(din),
		.debug_serial_clock_o(dclk), .hardware_breakpoint_request_o(bk));
	tap_tester i_tap_tester(.clk_i, .rst_b_i, .pins(pins), .trst_req_i(trq),
		.debug_mode_i(dmode), .dbg_si_i(si), .dbg_hardware_breakpoint_request_i(hardware_breakpoint_request), .cmd_valid_i(cv),
		.cmd_ready_o(cr), .cmd_kind_i(ck), .cmd_len_i(cl), .cmd_data_i(cd),
		.rsp_valid_o(rv), .rsp_data_o(rd), .dbg_so_o(debug_serial_out));
	tap_checks i_tap_checks(.clk_i, .rst_b_i, .test_port_select_strap_i(strap),
		.tck(pins.tck), .tms(pins.tms), .tdi(pins.tdi), .trst_b(pins.trst_b),
		.tdo_o(pins.tdo_o), .tdo_oe(pins.tdo_oe));

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task print_verdict;
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : print_verdict

	task chk(input logic [31:0] v, input logic [31:0] e);
		cmp_count++;
		if (v !== e) begin
			err_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, v, e);
		end
	endtask : chk

	// Bypass captures 0, boundary cells the pin value
	function automatic logic [31:0] exp_f(input logic ir, input logic [31:0] d);
		logic [63:0] w;
		if (ir) w = {29'h0, d, `TAP_IR_CAPTURE};
		else if (cur == `TAP_IR_IDCODE) w = {32'h0, `TAP_ID_VALUE};
		else if (cur == `TAP_IR_EXTEST || cur == `TAP_IR_SAMPLE) w = {24'h0, d, sp};
		else w = {31'h0, d, 1'b0};
		exp_f = w[31:0];
	endfunction : exp_f

	// Request held until the rising edge after ready is seen at a falling edge
	task cmd(input tst_cmd_t k, input logic [5:0] n, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		#1 ck = k;
		{cl, cd, cv} = {n, d, 1'b1};
		for (i = 0; i < 400; i++) begin
			@(negedge clk_i);
			if (cr === 1'b1) break;
		end
		@(posedge clk_i);
		#1 cv = 1'b0;
		for (i = (i == 400) ? 4000 : 0; i < 4000; i++) begin
			@(negedge clk_i);
			if (rv === 1'b1) break;
		end
		if (i == 4000) begin
			err_count++;
			print_verdict;
		end
	endtask : cmd

	// Pins held equal so capture order does not matter
	task scan(input logic ir, input logic [5:0] n, input logic [31:0] d);
		logic [31:0] m;
		logic [39:0] b;
		m = 32'((64'h1 << n) - 64'h1);
		@(posedge clk_i);
		#1 sp = {8{1'($random(seed))}};
		b = {d, sp};
		repeat (24) @(posedge clk_i);
		cmd(ir ? CMD_IR : CMD_DR, n, d);
		chk(rd & m, exp_f(ir, d) & m);
		if (ir) begin
			cur = d[n - 6'h1 -: 3];
			chk(hz, cur == `TAP_IR_HIGHZ);
			chk(ea, cur == `TAP_IR_EXTEST);
		end else if (cur == `TAP_IR_EXTEST || cur == `TAP_IR_SAMPLE) begin
			// Update cells keep the last eight bits that entered the chain
			chk(bsr, b[n +: 8]);
		end
		$display("scan done ir=%0d len=%0d", ir, n);
	endtask : scan

	initial begin
		logic [5:0] n;
		logic [31:0] d;
		{rst_b_i, so_i, so_oe, trq, dmode, si, hardware_breakpoint_request, cv} = '0;
		ck = CMD_IR;
		{strap, sp, cl, cd, cur} = {1'b1, 8'h0, 6'h3, 32'h0, `TAP_IR_IDCODE};
		{err_count, cmp_count, seed} = {32'h0, 32'h0, 32'd73597};
		repeat (8) @(posedge clk_i);
		#1 rst_b_i = 1'b1;
		scan(1'b0, 6'h20, $random(seed));
		for (int i = 0; i < 6; i++) begin
			n = (i == 0) ? 6'h3 : 6'h3 + 6'($unsigned($random(seed)) % 6);
			d = $random(seed);
			d[n - 6'h1 -: 3] = codes[i];
			scan(1'b1, n, d);
			scan(1'b0, 6'h1 + 6'($unsigned($random(seed)) % 32), $random(seed));
		end
		scan(1'b1, 6'h3, {29'h0, `TAP_IR_HIGHZ});
		cmd(CMD_RESET, 6'h0, 32'h0);
		cur = `TAP_IR_IDCODE;
		scan(1'b0, 6'h20, $random(seed));
		scan(1'b1, 6'h3, {29'h0, `TAP_IR_BYPASS});
		@(posedge clk_i);
		#1 trq = 1'b1;
		repeat (20) @(posedge clk_i);
		#1 trq = 1'b0;
		cur = `TAP_IR_IDCODE;
		scan(1'b0, 6'h20, $random(seed));
		@(posedge clk_i);
		#1 {strap, dmode, so_oe} = 3'h3;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			#1 {si, hardware_breakpoint_request, so_i} = 3'($random(seed));
			tv = pins.trst_b;
			repeat (2) @(posedge clk_i);
			#1 chk(dclk, tv);
			repeat (4) @(posedge clk_i);
			#1 chk(din, si);
			chk(bk, hardware_breakpoint_request);
			chk(debug_serial_out, so_i);
			chk(hz, 1'b0);
		end
		$display("debug port test done");
		// Clock back first, strap later: reset release never meets a TCK edge
		{dmode, so_oe} = 2'h0;
		repeat (4) @(posedge clk_i);
		#1 strap = 1'b1;
		repeat (16) @(posedge clk_i);
		scan(1'b0, 6'h20, $random(seed));
		print_verdict;
	end
endmodule : jtag_tap_controller_ir_bench
`default_nettype wire
